// ===== hdl/ecr_top.sv
// Encoder counter registers: position, velocity, interval timer and status
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ecr_top
  import ecr_pkg::*;
(
  input  wire logic              sys_clk,   // System clock, 100 MHz
  input  wire logic              resetn,    // Async reset, active low
  input  wire logic              index_pin, // Encoder index input
  input  wire logic              home_pin,  // Encoder home input
  input  wire logic              step_up,   // Decoder count-up pulse
  input  wire logic              step_down, // Decoder count-down pulse
  input  wire logic [ADDR_W-1:0] bus_addr,  // Register address
  input  wire logic [DATA_W-1:0] bus_wdata, // Write data
  input  wire logic              bus_wr,    // Write strobe
  input  wire logic              bus_rd,    // Read strobe
  output logic      [DATA_W-1:0] bus_rdata, // Read data, cycle after strobe
  output logic                   irq        // Interrupt request
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic              idx_en;
    logic              idx_flag;
    logic              hom_en;
    logic              hom_flag;
    logic              pci_en;
    logic              pci_flag;
    logic [MODE_W-1:0] mode;
    ecr_init_type      init;
    logic [CNT_W-1:0]  itmr;
    logic [CNT_W-1:0]  ihold;
    logic [DATA_W-1:0] rdata;
  } ecr_top_state_type;

  ecr_top_state_type st;
  ecr_top_state_type next_st;

  logic idx_rise;
  logic hom_rise;
  logic step_any;
  logic wr_stat;
  logic wr_ctrl;
  logic pos_clear;
  logic [DATA_W-1:0] rd_word;

  ecr_cnt_if pos_if ();
  ecr_cnt_if vel_if ();

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and counters

  ecr_sync u_index_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin     (index_pin),
    .level   (),
    .rise    (idx_rise)
  );

  ecr_sync u_home_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin     (home_pin),
    .level   (),
    .rise    (hom_rise)
  );

  ecr_count u_pos_count (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .port    (pos_if.cnt)
  );

  ecr_count u_vel_count (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .port    (vel_if.cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode and counter strobes

  assign step_any = step_up ^ step_down;
  assign wr_stat  = bus_wr && (bus_addr == OFS_STATUS);
  assign wr_ctrl  = bus_wr && (bus_addr == OFS_CONTROL);

  // Home reinitialises at once in one mode, at the next index in the other
  assign pos_clear = (hom_rise && (st.mode == MODE_HOME_RESET)) ||
                     (idx_rise && (st.init == INIT_ARMED));

  assign pos_if.inc     = step_up;
  assign pos_if.dec     = step_down;
  assign pos_if.clr     = pos_clear;
  assign pos_if.wr_lo   = bus_wr && (bus_addr == OFS_POS_LO);
  assign pos_if.wr_hi   = bus_wr && (bus_addr == OFS_POS_HI);
  assign pos_if.wr_hold = bus_wr && (bus_addr == OFS_POS_HOLD);
  assign pos_if.rd_lo   = bus_rd && (bus_addr == OFS_POS_LO);
  assign pos_if.wdata   = bus_wdata;

  // Velocity counts the same steps; software zeroes it by writing
  assign vel_if.inc     = step_up;
  assign vel_if.dec     = step_down;
  assign vel_if.clr     = 1'b0;
  assign vel_if.wr_lo   = bus_wr && (bus_addr == OFS_VEL_LO);
  assign vel_if.wr_hi   = bus_wr && (bus_addr == OFS_VEL_HI);
  assign vel_if.wr_hold = bus_wr && (bus_addr == OFS_VEL_HOLD);
  assign vel_if.rd_lo   = bus_rd && (bus_addr == OFS_VEL_LO);
  assign vel_if.wdata   = bus_wdata;

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  always_comb begin
    rd_word = WORD_ZERO;
    unique case (bus_addr)
      OFS_STATUS: begin
        rd_word[ST_IDX_EN]   = st.idx_en;
        rd_word[ST_IDX_FLAG] = st.idx_flag;
        rd_word[ST_HOM_EN]   = st.hom_en;
        rd_word[ST_HOM_FLAG] = st.hom_flag;
        rd_word[ST_PCI_EN]   = st.pci_en;
        rd_word[ST_PCI_FLAG] = st.pci_flag & ecr_homing_mode(st.mode);
      end
      OFS_CONTROL:  rd_word[MODE_W-1:0] = st.mode;
      OFS_POS_LO:   rd_word = pos_if.count[DATA_W-1:0];
      OFS_POS_HI:   rd_word = pos_if.count[CNT_W-1:DATA_W];
      OFS_POS_HOLD: rd_word = pos_if.hold;
      OFS_VEL_LO:   rd_word = vel_if.count[DATA_W-1:0];
      OFS_VEL_HI:   rd_word = vel_if.count[CNT_W-1:DATA_W];
      OFS_VEL_HOLD: rd_word = vel_if.hold;
      OFS_TMR_LO:   rd_word = st.itmr[DATA_W-1:0];
      OFS_TMR_HI:   rd_word = st.itmr[CNT_W-1:DATA_W];
      OFS_IHLD_LO:  rd_word = st.ihold[DATA_W-1:0];
      OFS_IHLD_HI:  rd_word = st.ihold[CNT_W-1:DATA_W];
      default:      rd_word = WORD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;

    // Enables are plain bits; flags clear on a written zero
    if (wr_stat) begin
      next_st.idx_en = bus_wdata[ST_IDX_EN];
      next_st.hom_en = bus_wdata[ST_HOM_EN];
      next_st.pci_en = bus_wdata[ST_PCI_EN];
    end
    next_st.idx_flag = ecr_sticky(st.idx_flag, idx_rise,
                                  wr_stat && !bus_wdata[ST_IDX_FLAG]);
    next_st.hom_flag = ecr_sticky(st.hom_flag, hom_rise,
                                  wr_stat && !bus_wdata[ST_HOM_FLAG]);
    next_st.pci_flag = ecr_sticky(st.pci_flag, pos_clear,
                                  wr_stat && !bus_wdata[ST_PCI_FLAG]);

    if (wr_ctrl) begin
      next_st.mode = bus_wdata[MODE_W-1:0];
    end

    // Arming only lives in the home-then-index mode
    unique case (st.init)
      INIT_IDLE: begin
        if (hom_rise && (st.mode == MODE_HOME_INDEX)) begin
          next_st.init = INIT_ARMED;
        end
      end
      INIT_ARMED: begin
        if (idx_rise || (st.mode != MODE_HOME_INDEX)) begin
          next_st.init = INIT_IDLE;
        end
      end
      default: next_st.init = INIT_IDLE;
    endcase

    // Interval timer measures clocks between steps, software write wins
    if (step_any) begin
      next_st.ihold = st.itmr;
      next_st.itmr  = CNT_ZERO;
    end else begin
      next_st.itmr = st.itmr + CNT_ONE;
    end
    if (bus_wr && (bus_addr == OFS_TMR_LO)) begin
      next_st.itmr[DATA_W-1:0] = bus_wdata;
    end
    if (bus_wr && (bus_addr == OFS_TMR_HI)) begin
      next_st.itmr[CNT_W-1:DATA_W] = bus_wdata;
    end
    if (bus_wr && (bus_addr == OFS_IHLD_LO)) begin
      next_st.ihold[DATA_W-1:0] = bus_wdata;
    end
    if (bus_wr && (bus_addr == OFS_IHLD_HI)) begin
      next_st.ihold[CNT_W-1:DATA_W] = bus_wdata;
    end

    // Data stands only in the cycle after the read strobe
    next_st.rdata = bus_rd ? rd_word : WORD_ZERO;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{idx_en: 1'b0, idx_flag: 1'b0, hom_en: 1'b0, hom_flag: 1'b0,
              pci_en: 1'b0, pci_flag: 1'b0, mode: MODE_RESET,
              init: INIT_IDLE, itmr: CNT_ZERO, ihold: CNT_ZERO,
              rdata: WORD_ZERO};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus_rdata = st.rdata;
  // Homing-done only raises the request in the modes where it means something
  assign irq = (st.idx_flag & st.idx_en) |
               (st.hom_flag & st.hom_en) |
               (st.pci_flag & st.pci_en & ecr_homing_mode(st.mode));

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_home_event;
    hom_rise;
  endsequence

  sequence s_pos_low_read;
    bus_rd && (bus_addr == OFS_POS_LO);
  endsequence

  sequence s_pos_low_write;
    bus_wr && (bus_addr == OFS_POS_LO);
  endsequence

  sequence s_quiet_timer;
    !step_any && !(bus_wr && (bus_addr == OFS_TMR_LO || bus_addr == OFS_TMR_HI));
  endsequence

  a_home_irq_gate: assert property (
    st.hom_flag && st.hom_en |-> irq)
    else $error("home flag enabled but no interrupt");

  a_home_irq_mask: assert property (
    !st.hom_en && !st.idx_en && !st.pci_en |-> !irq)
    else $error("interrupt with all enables clear");

  a_idx_flag_set: assert property (
    idx_rise |=> st.idx_flag)
    else $error("index event did not set flag");

  a_idx_flag_quiet: assert property (
    !st.idx_flag && !idx_rise |=> !st.idx_flag)
    else $error("index flag set without event");

  a_idx_irq_gate: assert property (
    st.idx_flag && st.idx_en |-> irq)
    else $error("index flag enabled but no interrupt");

  a_pci_mode_only: assert property (
    bus_rd && (bus_addr == OFS_STATUS) && !ecr_homing_mode(st.mode)
    |=> !bus_rdata[ST_PCI_FLAG])
    else $error("homing flag shown outside homing mode");

  a_home_reset_pos: assert property (
    s_home_event ##0 (st.mode == MODE_HOME_RESET) && !bus_wr
    |=> (pos_if.count == CNT_ZERO) && st.pci_flag)
    else $error("home event did not reinitialise position");

  a_pos_low_read: assert property (
    s_pos_low_read |=> bus_rdata == $past(pos_if.count[DATA_W-1:0]))
    else $error("position low read wrong");

  a_pos_high_read: assert property (
    bus_rd && (bus_addr == OFS_POS_HI)
    |=> bus_rdata == $past(pos_if.count[CNT_W-1:DATA_W]))
    else $error("position high read wrong");

  a_pos_hold_latch: assert property (
    s_pos_low_read |=> pos_if.hold == $past(pos_if.count[CNT_W-1:DATA_W]))
    else $error("low read did not latch position high word");

  a_pos_low_write: assert property (
    s_pos_low_write
    |=> pos_if.count == {$past(pos_if.hold), $past(bus_wdata)})
    else $error("low write did not load hold into high word");

  a_vel_hold_latch: assert property (
    bus_rd && (bus_addr == OFS_VEL_LO)
    |=> vel_if.hold == $past(vel_if.count[CNT_W-1:DATA_W]))
    else $error("velocity low read did not latch hold");

  a_vel_counts_up: assert property (
    step_up && !step_down && !bus_wr
    |=> vel_if.count == $past(vel_if.count) + CNT_ONE)
    else $error("velocity did not count up");

  a_itmr_counts: assert property (
    s_quiet_timer |=> st.itmr == $past(st.itmr) + CNT_ONE)
    else $error("interval timer did not advance");

  a_itmr_high_read: assert property (
    bus_rd && (bus_addr == OFS_TMR_HI)
    |=> bus_rdata == $past(st.itmr[CNT_W-1:DATA_W]))
    else $error("interval timer high read wrong");

  a_ihold_capture: assert property (
    step_any && !bus_wr |=> st.ihold == $past(st.itmr) && st.itmr == CNT_ZERO)
    else $error("interval hold did not capture timer");

  a_home_flag_set: assert property (
    s_home_event |=> st.hom_flag)
    else $error("home event did not set flag");

  a_flag_set_wins: assert property (
    idx_rise && wr_stat && !bus_wdata[ST_IDX_FLAG] && bus_wdata[ST_IDX_EN]
    |=> st.idx_flag ##0 irq)
    else $error("event lost against clear");

endmodule : ecr_top
`default_nettype wire

// ===== hdl/ecr_pkg.sv
// Shared constants, register map and types for the encoder counter registers
package ecr_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 32;
  localparam int MODE_W = 3;

  // Register map, one 16-bit register per address
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_POS_LO   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_POS_HI   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_POS_HOLD = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_VEL_LO   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_VEL_HI   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_VEL_HOLD = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_TMR_LO   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TMR_HI   = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_IHLD_LO  = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_IHLD_HI  = 4'hB;

  // Status field positions
  localparam int ST_IDX_EN   = 0;
  localparam int ST_IDX_FLAG = 1;
  localparam int ST_HOM_EN   = 2;
  localparam int ST_HOM_FLAG = 3;
  localparam int ST_PCI_EN   = 6;
  localparam int ST_PCI_FLAG = 7;

  // Position initialisation modes that use the home input, and the reset mode
  localparam logic [MODE_W-1:0] MODE_HOME_RESET = 3'h3;
  localparam logic [MODE_W-1:0] MODE_HOME_INDEX = 3'h4;
  localparam logic [MODE_W-1:0] MODE_RESET      = 3'h0;

  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 32'h0000_0001;

  typedef enum logic [1:0] {
    INIT_IDLE  = 2'b01,
    INIT_ARMED = 2'b10
  } ecr_init_type;

  function automatic logic ecr_homing_mode(input logic [MODE_W-1:0] mode);
    return (mode == MODE_HOME_RESET) || (mode == MODE_HOME_INDEX);
  endfunction : ecr_homing_mode

  // Sticky flag: hardware set wins over a software clear
  function automatic logic ecr_sticky(input logic flag, input logic set, input logic clr);
    return set | (flag & ~clr);
  endfunction : ecr_sticky

endpackage : ecr_pkg

// ===== hdl/ecr_cnt_if.sv
// Access bundle between the register logic and one split 32-bit counter
`timescale 1ns/10ps
`default_nettype none
interface ecr_cnt_if;
  import ecr_pkg::*;
  logic              inc;
  logic              dec;
  logic              clr;
  logic              wr_lo;
  logic              wr_hi;
  logic              wr_hold;
  logic              rd_lo;
  logic [DATA_W-1:0] wdata;
  logic [CNT_W-1:0]  count;
  logic [DATA_W-1:0] hold;
  modport ctl (output inc, dec, clr, wr_lo, wr_hi, wr_hold, rd_lo, wdata,
               input count, hold);
  modport cnt (input inc, dec, clr, wr_lo, wr_hi, wr_hold, rd_lo, wdata,
               output count, hold);
endinterface : ecr_cnt_if
`default_nettype wire

// ===== hdl/ecr_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
`default_nettype none
module ecr_sync (
  input  wire logic sys_clk, // System clock
  input  wire logic resetn,  // Async reset, active low
  input  wire logic pin,     // Asynchronous input pin
  output logic      level,   // Filtered level
  output logic      rise     // One-cycle pulse on a rising level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } ecr_sync_state_type;

  ecr_sync_state_type st;
  ecr_sync_state_type next_st;

  always_comb begin
    next_st      = st;
    next_st.s1   = pin;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = 1'b0;
    // Only stages two and three decide, stage one only feeds stage two
    if (st.s2 == st.s3) begin
      next_st.lvl  = st.s3;
      next_st.rise = st.s3 & ~st.lvl;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
  assign rise  = st.rise;
endmodule : ecr_sync
`default_nettype wire

// ===== hdl/ecr_count.sv
// Split 32-bit up/down counter with a 16-bit hold register for the high word
`timescale 1ns/10ps
`default_nettype none
module ecr_count
  import ecr_pkg::*;
(
  input  wire logic sys_clk, // System clock
  input  wire logic resetn,  // Async reset, active low
  ecr_cnt_if.cnt    port     // Strobes in, count and hold out
);
  typedef struct packed {
    logic [CNT_W-1:0]  count;
    logic [DATA_W-1:0] hold;
  } ecr_count_state_type;

  ecr_count_state_type st;
  ecr_count_state_type next_st;

  always_comb begin
    next_st = st;
    if (port.wr_lo) begin
      next_st.count = {st.hold, port.wdata};
    end else if (port.wr_hi) begin
      next_st.count[CNT_W-1:DATA_W] = port.wdata;
    end else if (port.clr) begin
      next_st.count = CNT_ZERO;
    end else if (port.inc && !port.dec) begin
      next_st.count = st.count + CNT_ONE;
    end else if (port.dec && !port.inc) begin
      next_st.count = st.count - CNT_ONE;
    end
    // Low read snapshots the high word into the hold register so a later hold read is coherent
    if (port.wr_hold) begin
      next_st.hold = port.wdata;
    end else if (port.rd_lo) begin
      next_st.hold = st.count[CNT_W-1:DATA_W];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{count: CNT_ZERO, hold: WORD_ZERO};
    end else begin
      st <= next_st;
    end
  end

  assign port.count = st.count;
  assign port.hold  = st.hold;
endmodule : ecr_count
`default_nettype wire

// ===== verif/ecr_encoder_model.sv
// Encoder and decoder front end driving the index, home and step inputs
`timescale 1ns/10ps
`default_nettype none
module ecr_encoder_model (
  input  wire logic sys_clk,   // System clock
  output logic      index_pin, // Index output, idles low
  output logic      home_pin,  // Home output, idles low
  output logic      step_up,   // Count-up pulse
  output logic      step_down  // Count-down pulse
);
  initial begin
    index_pin = 1'b0;
    home_pin  = 1'b0;
    step_up   = 1'b0;
    step_down = 1'b0;
  end

  // Pin held high four cycles so the input filter agrees on it
  task automatic pulse_pin(input logic home);
    @(posedge sys_clk);
    if (home) begin
      home_pin <= 1'b1;
    end else begin
      index_pin <= 1'b1;
    end
    repeat (4) @(posedge sys_clk);
    home_pin  <= 1'b0;
    index_pin <= 1'b0;
  endtask : pulse_pin

  // Back-to-back pulses, one per cycle
  task automatic steps(input logic up, input logic dn, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      step_up   <= up;
      step_down <= dn;
    end
    @(posedge sys_clk);
    step_up   <= 1'b0;
    step_down <= 1'b0;
  endtask : steps
endmodule : ecr_encoder_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the encoder counter registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ecr_pkg::*;
  logic              sys_clk;
  logic              resetn;
  logic              index_pin;
  logic              home_pin;
  logic              step_up;
  logic              step_down;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic              irq;
  int                n_errors;
  int                tests_run;

  ecr_top uut (.sys_clk(sys_clk), .resetn(resetn), .index_pin(index_pin),
    .home_pin(home_pin), .step_up(step_up), .step_down(step_down),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq));

  ecr_encoder_model enc (.sys_clk(sys_clk), .index_pin(index_pin),
    .home_pin(home_pin), .step_up(step_up), .step_down(step_down));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic ck16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck16

  task automatic ck1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck1

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    ck16(bus_rdata, exp);
  endtask : rd

  // Synchroniser latency is about five cycles after the pin pulse
  task automatic pin_event(input logic home);
    enc.pulse_pin(home);
    repeat (6) @(posedge sys_clk);
  endtask : pin_event

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_errors++;
    give_verdict();
  end

  initial begin
    n_errors  = 0;
    tests_run = 0;
    resetn    = 1'b0;
    bus_addr  = '0;
    bus_wdata = WORD_ZERO;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    // Free-running timer words excluded from the reset sweep
    for (int a = 0; a < 16; a++) begin
      if (a != 8 && a != 9) begin
        rd(a[ADDR_W-1:0], WORD_ZERO);
      end
    end
    ck1(irq, 1'b0);
    // Interval timer and its hold
    wr(OFS_TMR_LO, 16'h0000);
    wr(OFS_TMR_HI, 16'hABCD);
    rd(OFS_TMR_HI, 16'hABCD);
    wr(OFS_IHLD_LO, 16'h1111);
    wr(OFS_IHLD_HI, 16'h2222);
    rd(OFS_IHLD_LO, 16'h1111);
    rd(OFS_IHLD_HI, 16'h2222);
    enc.steps(1'b1, 1'b0, 1);
    rd(OFS_IHLD_HI, 16'hABCD);
    rd(OFS_TMR_HI, 16'h0000);
    // Split writes across the low-word carry
    wr(OFS_POS_HOLD, 16'h1234);
    wr(OFS_POS_LO, 16'hFFFF);
    wr(OFS_VEL_HOLD, 16'h0002);
    wr(OFS_VEL_LO, 16'hFFFE);
    enc.steps(1'b1, 1'b0, 3);
    enc.steps(1'b0, 1'b1, 1);
    enc.steps(1'b1, 1'b1, 2);
    rd(OFS_POS_LO, 16'h0001);
    rd(OFS_POS_HOLD, 16'h1235);
    rd(OFS_POS_HI, 16'h1235);
    rd(OFS_VEL_LO, 16'h0000);
    rd(OFS_VEL_HOLD, 16'h0003);
    rd(OFS_VEL_HI, 16'h0003);
    wr(OFS_POS_HI, 16'h00AA);
    rd(OFS_POS_HI, 16'h00AA);
    wr(OFS_VEL_HI, 16'h0055);
    rd(OFS_VEL_HI, 16'h0055);
    // Event flags and enables
    wr(OFS_STATUS, 16'h0005);
    rd(OFS_STATUS, 16'h0005);
    ck1(irq, 1'b0);
    pin_event(1'b0);
    rd(OFS_STATUS, 16'h0007);
    ck1(irq, 1'b1);
    wr(OFS_STATUS, 16'h0004);
    rd(OFS_STATUS, 16'h0004);
    ck1(irq, 1'b0);
    pin_event(1'b1);
    rd(OFS_STATUS, 16'h000C);
    ck1(irq, 1'b1);
    wr(OFS_STATUS, 16'h0008);
    rd(OFS_STATUS, 16'h0008);
    ck1(irq, 1'b0);
    pin_event(1'b0);
    rd(OFS_STATUS, 16'h000A);
    ck1(irq, 1'b0);
    // Homing mode 011: home edge clears the count
    wr(OFS_STATUS, 16'h0000);
    wr(OFS_CONTROL, 16'h0003);
    pin_event(1'b1);
    rd(OFS_STATUS, 16'h0088);
    rd(OFS_POS_LO, 16'h0000);
    rd(OFS_POS_HOLD, 16'h0000);
    wr(OFS_CONTROL, 16'h0000);
    rd(OFS_STATUS, 16'h0008);
    // Homing mode 100: home arms, index clears
    wr(OFS_STATUS, 16'h0040);
    wr(OFS_CONTROL, 16'h0004);
    wr(OFS_POS_LO, 16'h0066);
    pin_event(1'b1);
    rd(OFS_STATUS, 16'h0048);
    rd(OFS_POS_LO, 16'h0066);
    ck1(irq, 1'b0);
    pin_event(1'b0);
    rd(OFS_STATUS, 16'h00CA);
    ck1(irq, 1'b1);
    rd(OFS_POS_LO, 16'h0000);
    wr(OFS_CONTROL, 16'h0000);
    rd(OFS_STATUS, 16'h004A);
    ck1(irq, 1'b0);
    // Clearing write lands on the edge where the index event sets the flag
    wr(OFS_STATUS, 16'h0000);
    fork
      enc.pulse_pin(1'b0);
      begin
        repeat (4) @(posedge sys_clk);
        wr(OFS_STATUS, 16'h0001);
      end
    join
    rd(OFS_STATUS, 16'h0003);
    ck1(irq, 1'b1);
    // Mid-run reset returns registers and flags to zero
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFS_STATUS, WORD_ZERO);
    ck1(irq, 1'b0);
    rd(OFS_POS_HI, WORD_ZERO);
    rd(OFS_VEL_HI, WORD_ZERO);
    rd(OFS_IHLD_HI, WORD_ZERO);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
